// ===== bench/sflag_dev_model.sv
// Purpose: behavioural flag bank of one memory port
// Assumes: the opposite port stays idle
// Notes: released data lines show the inverse of the last value
`include "sflag_defines.svh"
`default_nettype none
module sflag_dev_model
  import sflag_pkg::*;
(
  // pins from the host
  input  wire sflag_pins_t               pins_in,
  input  wire logic [`SFLAG_DATA_W-1:0]  wdata_in,
  // data lines back to the host
  output logic [`SFLAG_DATA_W-1:0]       rdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // flag bank
  // ****************
  logic [7:0]               flag_r = 8'hff;  // all flags free at power-up
  logic [`SFLAG_DATA_W-1:0] last_r = 16'h0000;
  wire logic off = pins_in.chip_sel_n | (pins_in.high_byte_select_n & pins_in.low_byte_select_n);
  wire logic sel = !pins_in.flag_bank_select_n & off;
  // write takes bit zero of the bus only, oe ignored
  always @* begin
    if (sel && !pins_in.rw_n) flag_r[pins_in.addr[2:0]] = wdata_in[0];
  end
  // read copies the flag to every line; hold is short, so release shows garbage
  always @* begin
    if (sel && pins_in.rw_n && !pins_in.out_en_n) last_r = {16{flag_r[pins_in.addr[2:0]]}};
  end
  assign rdata_out = (sel && pins_in.rw_n && !pins_in.out_en_n) ? last_r : ~last_r;
endmodule : sflag_dev_model
`default_nettype wire

// ===== bench/sflag_host_props.sv
// Purpose: pin protocol checks of the flag host
// Assumes: default access width of two cycles
// Notes: sees only top-level ports
`include "sflag_defines.svh"
`default_nettype none
module sflag_host_props
  import sflag_pkg::*;
#(
  parameter int ACCESS_CYC = 2
) (
  // clock, reset and watched outputs
  input wire logic                     sys_clk_in,
  input wire logic                     rst_n_in,
  input wire logic                     rsp_valid_out,
  input wire sflag_pins_t              pins_out,
  input wire logic [`SFLAG_DATA_W-1:0] data_out,
  input wire logic                     data_oe_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  wire logic fs = pins_out.flag_bank_select_n;
  wire logic rw = pins_out.rw_n;
  // port must stay deselected, bytes high
  property p_port_off; pins_out.chip_sel_n && pins_out.high_byte_select_n && pins_out.low_byte_select_n; endproperty
  a_port_off: assert property (p_port_off) else $error("port selected");
  property p_read_oe; !fs && rw |-> !pins_out.out_en_n; endproperty
  a_read_oe: assert property (p_read_oe) else $error("read without oe");
  property p_read_len; $fell(fs) && rw |-> !fs [*4] ##1 fs; endproperty
  a_read_len: assert property (p_read_len) else $error("read strobe length");
  property p_write_len; $fell(fs) && !rw |-> (!rw && data_oe_out) [*2] ##1 (fs && rw); endproperty
  a_write_len: assert property (p_write_len) else $error("write strobe");
  // a gap keeps the flag update pulse before the read-back
  property p_recover; (!fs && !rw) ##1 rw |-> fs; endproperty
  a_recover: assert property (p_recover) else $error("no recovery gap");
  property p_data_bits; data_oe_out |-> data_out[15:1] == 15'h0000 && !fs && !rw; endproperty
  a_data_bits: assert property (p_data_bits) else $error("data while idle");
  property p_addr_hold; !fs && !$past(fs) |-> $stable(pins_out.addr); endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved");
  property p_answer; $fell(fs) && rw |-> ##4 rsp_valid_out; endproperty
  a_answer: assert property (p_answer) else $error("late answer");
endmodule : sflag_host_props
bind sflag_host sflag_host_props #(.ACCESS_CYC(ACCESS_CYC)) sflag_host_props_inst (.sys_clk_in(sys_clk_in),
  .rst_n_in(rst_n_in), .rsp_valid_out(rsp_valid_out), .pins_out(pins_out), .data_out(data_out),
  .data_oe_out(data_oe_out));
`default_nettype wire

// ===== bench/testbench.sv
// Purpose: self-checking bench of the flag host
// Assumes: one port, opposite port idle
// Notes: corner sweep, then seeded random traffic
`include "sflag_defines.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import sflag_pkg::*;
  logic sys_clk_in, rst_n_in, cmd_valid_in, cmd_ready_out, rsp_valid_out, rsp_flag_out, rsp_granted_out, data_oe_out;
  sflag_cmd_t  cmd_in;
  sflag_pins_t pins_out;
  logic [15:0] data_in, data_out, dev_data;
  logic [31:0] r;
  logic [7:0]  exp_flag = 8'hff;
  int err_total = 0, comparisons = 0, seed = 32'h6c4d, cyc = 0;
  assign data_in = data_oe_out ? data_out : dev_data;  // host drive wins only on write
  sflag_host sflag_host_inst (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid_in),
    .cmd_in(cmd_in), .cmd_ready_out(cmd_ready_out), .rsp_valid_out(rsp_valid_out), .rsp_flag_out(rsp_flag_out),
    .rsp_granted_out(rsp_granted_out), .pins_out(pins_out), .data_in(data_in), .data_out(data_out),
    .data_oe_out(data_oe_out));
  sflag_dev_model sflag_dev_model_inst (.pins_in(pins_out), .wdata_in(data_out), .rdata_out(dev_data));
  // expected flag after one command on an otherwise idle device: a write stores bit zero
  function automatic logic predict_flag(input logic [7:0] bank, input logic w, input logic [2:0] idx, input logic v);
    return w ? v : bank[idx];
  endfunction : predict_flag
  task automatic check(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // one command; entered and left at a falling edge
  task automatic run_cmd(input logic w, input logic [2:0] idx, input logic v);
    while (cmd_ready_out !== 1'b1) @(negedge sys_clk_in);
    cmd_in = {w, idx, v};
    cmd_valid_in = 1'b1;
    @(negedge sys_clk_in);
    cmd_valid_in = 1'b0;
    while (rsp_valid_out !== 1'b1) @(negedge sys_clk_in);
    check(rsp_flag_out, predict_flag(exp_flag, w, idx, v));
    check(rsp_granted_out, w);
    if (w) exp_flag[idx] = v;
  endtask : run_cmd
  task automatic complete_run();
    $display("comparisons=%0d mismatches=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  initial begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end
  // hang guard, far above the run's length
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc > 3000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    rst_n_in = 1'b0;
    cmd_valid_in = 1'b0;
    cmd_in = '0;
    repeat (3) @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    run_cmd(1'b0, 3'h5, 1'b0);
    for (int i = 0; i < 8; i++) run_cmd(1'b1, i[2:0], 1'b0);
    for (int i = 7; i >= 0; i--) run_cmd(1'b0, i[2:0], 1'b0);
    $display("test corner done");
    for (int i = 0; i < 60; i++) begin
      r = $random(seed);
      run_cmd(r[0], r[3:1], r[4]);
    end
    $display("test random done");
    // mid-run reset between commands: host outputs clear, the device keeps its flags
    @(negedge sys_clk_in);
    rst_n_in = 1'b0;
    @(negedge sys_clk_in);
    check(cmd_ready_out, 1'b0);
    check(rsp_valid_out, 1'b0);
    check(pins_out.flag_bank_select_n, 1'b1);
    check(data_oe_out, 1'b0);
    rst_n_in = 1'b1;
    for (int i = 0; i < 8; i++) run_cmd(1'b0, i[2:0], 1'b0);
    $display("test reset done");
    complete_run();
  end
endmodule : testbench
`default_nettype wire

// ===== rtl/sflag_defines.svh
// Purpose: timing counts and field positions for the semaphore flag host controller
// Assumes: 10 MHz system clock (100 ns period)
// Notes:   definitions only
`ifndef SFLAG_DEFINES_SVH
`define SFLAG_DEFINES_SVH

// ****************************************
// timing
// ****************************************
`define SFLAG_CLK_PERIOD_NS   100
`define SFLAG_UPDATE_PULSE_NS 10
// least time rounds up, never below one cycle
`define SFLAG_UPDATE_CYC ((`SFLAG_UPDATE_PULSE_NS + `SFLAG_CLK_PERIOD_NS - 1) / `SFLAG_CLK_PERIOD_NS)
// write strobe width of one access, in cycles; the read strobe is two cycles longer
`define SFLAG_ACCESS_CYC 2

// ****************************************
// fields
// ****************************************
`define SFLAG_IDX_W  3
`define SFLAG_DATA_W 16
`define SFLAG_ADDR_W 16
`define SFLAG_FLAG_BIT 0

`endif

// ===== rtl/sflag_host.sv
// Purpose: host side controller that reads and claims the eight semaphore flags of a dual-port memory
// Assumes: device pins are asynchronous; read data passes a two-flop synchroniser
// Notes:   one access at a time; a write is always followed by a read-back of the same flag
//          ACCESS_CYC above 14 overflows the four-bit phase counter
//
// Behaviour
// - semaphore read: flag select low, rw high, oe low, port off, both bytes high.
// - semaphore write: flag select low, rw low, port off, bytes high; oe irrelevant.
// - host keeps oe or flag select inactive one update pulse between write and read.
// - busy matters only when the other port finishes a write; not for reads.
`include "sflag_defines.svh"
`default_nettype none

module sflag_host
  import sflag_pkg::*;
#(
  parameter int ACCESS_CYC = `SFLAG_ACCESS_CYC
) (
  // clock and reset
  input  wire  logic                     sys_clk_in,
  input  wire  logic                     rst_n_in,
  // user command side
  input  wire  logic                     cmd_valid_in,
  input  wire  sflag_cmd_t               cmd_in,
  output logic                           cmd_ready_out,
  output logic                           rsp_valid_out,
  output logic                           rsp_flag_out,
  output logic                           rsp_granted_out,
  // memory port pins
  output sflag_pins_t                    pins_out,
  input  wire  logic [`SFLAG_DATA_W-1:0] data_in,
  output logic [`SFLAG_DATA_W-1:0]       data_out,
  output logic                           data_oe_out
);

  localparam int RECOV_CYC = `SFLAG_UPDATE_CYC;
  localparam int CNT_W     = 4;

  sflag_state_t            state_r;
  logic [CNT_W-1:0]        cnt_r;
  sflag_cmd_t              cmd_r;
  logic [`SFLAG_DATA_W-1:0] sync1_r;
  logic [`SFLAG_DATA_W-1:0] sync2_r;
  logic                     step_done;

  // idle pins: port off, bytes off, flag bank off, read direction
  function automatic sflag_pins_t idle_pins();
    sflag_pins_t p;
    p                    = '0;
    p.chip_sel_n         = 1'b1;
    p.rw_n               = 1'b1;
    p.out_en_n           = 1'b1;
    p.flag_bank_select_n = 1'b1;
    p.high_byte_select_n = 1'b1;
    p.low_byte_select_n  = 1'b1;
    return p;
  endfunction : idle_pins

  // counter end test shared by every timed phase
  function automatic logic cnt_at(input logic [CNT_W-1:0] cnt, input int limit);
    return cnt == CNT_W'(limit);
  endfunction : cnt_at

  // flag value carried by a synchronised data word
  function automatic logic flag_of(input logic [`SFLAG_DATA_W-1:0] word);
    return word[`SFLAG_FLAG_BIT];
  endfunction : flag_of

  // ****************************************
  // input synchroniser
  // ****************************************
  // data pins are asynchronous; only the second flop is read
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_r <= 16'h0000;
      sync2_r <= 16'h0000;
    end else begin
      sync1_r <= data_in;
      sync2_r <= sync1_r;
    end
  end

  // ****************************************
  // command capture
  // ****************************************
  // latched once at take and held for the whole access, so a changing cmd_in cannot disturb it
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cmd_r <= '0;
    end else if ((state_r == SF_IDLE) && cmd_valid_in) begin
      cmd_r <= cmd_in;
    end
  end

  // ****************************************
  // phase timing
  // ****************************************
  // end of the timed phase of the current state; untimed states end at once
  always_comb begin
    step_done = 1'b0;
    unique case (state_r)
      SF_IDLE:  step_done = 1'b1;
      SF_WR:    step_done = cnt_at(cnt_r, ACCESS_CYC - 1);
      SF_RECOV: step_done = cnt_at(cnt_r, RECOV_CYC - 1);
      SF_RD:    step_done = cnt_at(cnt_r, ACCESS_CYC + 1); // synchroniser latency plus the strobe
      SF_DONE:  step_done = 1'b1;
    endcase
  end

  // one counter serves every timed state and restarts whenever a phase ends
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r <= '0;
    end else if (step_done) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  // a write holds its strobe ACCESS_CYC cycles, a read ACCESS_CYC + 2, so the synchroniser settles before sampling
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= SF_IDLE;
    end else begin
      unique case (state_r)
        SF_IDLE: begin
          if (cmd_valid_in) begin
            state_r <= cmd_in.write ? SF_WR : SF_RD;
          end
        end
        SF_WR: begin
          if (step_done) begin
            state_r <= SF_RECOV;
          end
        end
        SF_RECOV: begin
          // flag select held high for the update pulse before read-back
          if (step_done) begin
            state_r <= SF_RD;
          end
        end
        SF_RD: begin
          if (step_done) begin
            state_r <= SF_DONE;
          end
        end
        SF_DONE: begin
          state_r <= SF_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // pin drive
  // ****************************************
  // port and both bytes stay deselected in every state, so flag select never meets a low byte select
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pins_out <= idle_pins();
    end else begin
      pins_out      <= idle_pins();
      pins_out.addr <= {{(`SFLAG_ADDR_W-`SFLAG_IDX_W){1'b0}}, cmd_r.idx}; // flag index on low bits
      if (state_r == SF_WR) begin
        pins_out.flag_bank_select_n <= 1'b0;   // write strobe, oe left high
        pins_out.rw_n               <= 1'b0;
      end else if (state_r == SF_RD) begin
        pins_out.flag_bank_select_n <= 1'b0;   // read strobe
        pins_out.out_en_n           <= 1'b0;
      end
    end
  end

  // write data is driven only inside the write strobe, so it never fights the device's read drive
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      data_out    <= 16'h0000;
      data_oe_out <= 1'b0;
    end else begin
      data_out    <= 16'h0000;
      data_oe_out <= (state_r == SF_WR);
      if (state_r == SF_WR) begin
        data_out[`SFLAG_FLAG_BIT] <= cmd_r.value; // only bit zero carries the request
      end
    end
  end

  // ****************************************
  // response
  // ****************************************
  // bit zero is sampled; all lines carry the same flag so any bit would do
  // busy is not watched: flag reads never depend on it
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rsp_valid_out   <= 1'b0;
      rsp_flag_out    <= 1'b0;
      rsp_granted_out <= 1'b0;
    end else begin
      rsp_valid_out <= (state_r == SF_DONE);
      if (state_r == SF_DONE) begin
        rsp_flag_out    <= flag_of(sync2_r);
        // claim written as 0 is won when read-back shows 0; one port only wins
        rsp_granted_out <= cmd_r.write && (flag_of(sync2_r) == cmd_r.value);
      end
    end
  end

  // ready is registered, falls on the edge that takes a command and rises one cycle after idle returns; a requester must hold valid until taken
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cmd_ready_out <= 1'b0;
    end else begin
      cmd_ready_out <= (state_r == SF_IDLE) && !cmd_valid_in;
    end
  end

endmodule : sflag_host

`default_nettype wire

// ===== rtl/sflag_pkg.sv
// Purpose: types of the semaphore flag host controller
// Assumes: sflag_defines.svh is on the include path
// Notes:   packed structs carry the pin group and the command
`include "sflag_defines.svh"
`default_nettype none

package sflag_pkg;

  // ****************************************
  // pin group toward the memory port
  // ****************************************
  typedef struct packed {
    logic                      chip_sel_n;
    logic                      rw_n;
    logic                      out_en_n;
    logic                      flag_bank_select_n;
    logic                      high_byte_select_n;
    logic                      low_byte_select_n;
    logic [`SFLAG_ADDR_W-1:0]  addr;
  } sflag_pins_t;

  // ****************************************
  // user command
  // ****************************************
  typedef struct packed {
    logic                      write;
    logic [`SFLAG_IDX_W-1:0]   idx;
    logic                      value;
  } sflag_cmd_t;

  typedef enum logic [4:0] {
    SF_IDLE  = 5'b00001,
    SF_WR    = 5'b00010,
    SF_RECOV = 5'b00100,
    SF_RD    = 5'b01000,
    SF_DONE  = 5'b10000
  } sflag_state_t;

endpackage : sflag_pkg

`default_nettype wire
